// ---- core/sci_pkg.sv ----
// constants and types shared by the serial interface files
package sci_pkg;

  // ==========================================================================
  // register map (index; byte address is four times the index)
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_RATE = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_RXDATA = 6'h12;
  localparam logic [5:0] IDX_TXDATA = 6'h13;

  // ==========================================================================
  // field positions
  localparam int ST_FULL = 7;
  localparam int ST_RX_OVERRUN_OR_FRAMING = 6;
  localparam int ST_TX_BUFFER_EMPTY = 5;
  localparam int ST_RIE = 4;
  localparam int ST_RE = 3;
  localparam int ST_TIE = 2;
  localparam int ST_TE = 1;
  localparam int RT_EBE = 7;
  localparam int RT_FMT_HI = 3;
  localparam int RT_FMT_LO = 2;
  localparam int RT_SPD_HI = 1;
  localparam int RT_SPD_LO = 0;
  localparam logic [7:0] STATUS_RESET = 8'h20;

  // ==========================================================================
  // format and clock select codes
  localparam logic [1:0] FMT_BIPHASE = 2'h0;
  localparam logic [1:0] FMT_NRZ_INT = 2'h1;
  localparam logic [1:0] FMT_NRZ_CLKOUT = 2'h2;
  localparam logic [1:0] FMT_NRZ_EXT = 2'h3;

  // ==========================================================================
  // bit timing
  localparam int OVERSAMPLE = 8;
  localparam int PRE_W = 10;
  localparam logic [2:0] PHASE_LAST = 3'h7;
  localparam logic [2:0] PHASE_HALF = 3'h4;
  localparam logic [2:0] PHASE_TX_MID = 3'h3;
  localparam logic [2:0] PHASE_START_CHK = 3'h3;
  localparam logic [2:0] PHASE_Q1 = 3'h2;
  localparam logic [2:0] PHASE_Q3 = 3'h6;
  localparam logic [3:0] PREAMBLE_BITS = 4'h9;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam logic [3:0] STOP_CELL = 4'h9;

  // E divisors per bit, standard and extra rate sets
  function automatic logic [12:0] bit_divisor(input logic ebe,
                                              input logic [1:0] spd);
    logic [12:0] d;
    d = 13'h0010;
    unique case ({ebe, spd})
      3'h0: d = 13'h0010;
      3'h1: d = 13'h0080;
      3'h2: d = 13'h0400;
      3'h3: d = 13'h1000;
      3'h4: d = 13'h0040;
      3'h5: d = 13'h0100;
      3'h6: d = 13'h0200;
      3'h7: d = 13'h0800;
    endcase
    return d;
  endfunction : bit_divisor

  typedef enum logic [1:0] {TX_OFF, TX_PREAMBLE, TX_IDLE, TX_FRAME} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_CELL, RX_BREAK} rx_state_e;

endpackage : sci_pkg

// ---- core/pin_sync.sv ----
// three-stage synchroniser for a pin level
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // pin and result
  input wire logic pin_in,
  output logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a change counts only when the last two stages agree
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st <= 4'hF;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  assign level_out = st.level;
endmodule : pin_sync
`default_nettype wire

// ---- core/async_serial_comm_interface.sv ----
// full-duplex asynchronous serial interface with avalon register slave
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// (RQ1) rising tx_on connects tx_pin and sends nine ones before data
// (RQ2) tx_irq_on routes transmit request to shared_irq_line; reset clears enables
// (RQ3) rx_on locks rx_pin as input for good; receiver runs only with rx_on
// (RQ4) rx_irq_on raises shared_irq_line on buffer full or error flag
// (RQ5) tx_buffer_empty set on shifter load and reset; cleared by read then write
// (RQ6) transmitter takes data only after tx_buffer_empty was cleared
// (RQ7) new byte with rx_buffer_full still set flags overrun
// (RQ8) missing stop bit flags framing error
// (RQ9) error flag with full set means overrun, with full clear framing
// (RQ10) overrun discards the new byte, receive register kept
// (RQ11) framing error stores byte, then blocks transfers until flag cleared
// (RQ12) error flag cleared by status read then data read, or reset
// (RQ13) rx_buffer_full set when shifter moves into receive register
// (RQ14) software writes rate register first, then control/status register
// (RQ15) after preamble idle ones, or load pending byte on bit clock
// (RQ16) frame is start 0, eight data bits lsb first, stop 1
// (RQ17) empty buffer at byte boundary sends continuous ones
// (RQ18) biphase toggles at each cell start and mid-cell for a one
// (RQ19) reset loads control/status with only tx_buffer_empty set
// (RQ20) format_clock_select picks biphase, nrz, clock out or external clock
// (RQ21) speed_divider_select and extra_rates_select pick the E divisor
// (RQ22) receiver finds start edge and samples cells at eight ticks per bit
// (RQ23) rx_buffer_full cleared by status read then data read, or reset
module async_serial_comm_interface
  import sci_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // serial pins
  output logic tx_pin_out,
  output logic tx_pin_oe_n_out,
  input wire logic rx_pin_in,
  output logic rx_pin_input_lock_out,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n_out,
  // interrupt request level
  output logic shared_irq_line_out
);

  typedef struct packed {
    logic bus_wait;
    logic [7:0] rdata;
    logic ebe;
    logic [1:0] fmt;
    logic [1:0] speed;
    logic te;
    logic tx_irq_on;
    logic re;
    logic rx_irq_on;
    logic tx_buffer_empty;
    logic full;
    logic rx_overrun_or_framing;
    logic tx_buffer_empty_armed;
    logic full_armed;
    logic rx_overrun_or_framing_armed;
    logic [7:0] tdr;
    logic [7:0] rdr;
    logic [PRE_W-1:0] pre_cnt;
    logic tick8;
    logic ext_prev;
    tx_state_e tx_state;
    logic te_prev;
    logic [2:0] tx_phase;
    logic [3:0] tx_cnt;
    logic [8:0] tx_shift;
    logic tx_bit;
    logic tx_line;
    logic tx_oe_n;
    rx_state_e rx_state;
    logic [2:0] rx_phase;
    logic [3:0] rx_cnt;
    logic [7:0] rx_shift;
    logic q1;
    logic qmid;
    logic rx_lock;
    logic irq;
    logic sclk;
    logic sclk_oe_n;
  } state_s;

  state_s st;
  state_s next_st;
  logic rx_line;
  logic ext_clk;

  // ==========================================================================
  // pin synchronisers
  pin_sync rx_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .pin_in(rx_pin_in),
    .level_out(rx_line)
  );

  pin_sync clk_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .pin_in(serial_clock_pin_in),
    .level_out(ext_clk)
  );

  // ==========================================================================
  // register readback
  function automatic logic [7:0] read_value(input state_s s,
                                            input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_STATUS) begin
      v[ST_FULL] = s.full;
      v[ST_RX_OVERRUN_OR_FRAMING] = s.rx_overrun_or_framing;
      v[ST_TX_BUFFER_EMPTY] = s.tx_buffer_empty;
      v[ST_RIE] = s.rx_irq_on;
      v[ST_RE] = s.re;
      v[ST_TIE] = s.tx_irq_on;
      v[ST_TE] = s.te;
    end else if (idx == IDX_RXDATA) begin
      v = s.rdr;
    end
    return v;
  endfunction : read_value

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic req;
    logic accept;
    logic aligned;
    logic [5:0] idx;
    logic [12:0] div;
    logic [PRE_W-1:0] div8;
    logic tick;
    logic bit_tick;
    logic mid_tick;
    logic load_next;
    logic cell_bit;
    req = 1'b0;
    accept = 1'b0;
    aligned = 1'b0;
    idx = 6'h00;
    div = 13'h0000;
    div8 = '0;
    tick = 1'b0;
    bit_tick = 1'b0;
    mid_tick = 1'b0;
    load_next = 1'b0;
    cell_bit = 1'b0;
    next_st = st;

    // bus slave: one wait cycle, then the access completes
    req = avs_read_in | avs_write_in;
    idx = avs_address_in[ADDR_W-1:2];
    aligned = (avs_address_in[1:0] == 2'h0);
    if (!aligned) begin
      idx = 6'h00;
    end
    accept = req & ~st.bus_wait;
    if (req && st.bus_wait) begin
      next_st.bus_wait = 1'b0;
      next_st.rdata = avs_read_in ? read_value(st, idx) : 8'h00;
    end else begin
      next_st.bus_wait = 1'b1;
    end

    // read and write side effects at the completing edge
    if (accept && avs_read_in && idx == IDX_STATUS) begin
      if (st.tx_buffer_empty) next_st.tx_buffer_empty_armed = 1'b1;
      if (st.full) next_st.full_armed = 1'b1;
      if (st.rx_overrun_or_framing) next_st.rx_overrun_or_framing_armed = 1'b1;
    end
    if (accept && avs_read_in && idx == IDX_RXDATA) begin
      if (st.full_armed) next_st.full = 1'b0; // RQ23
      if (st.rx_overrun_or_framing_armed) next_st.rx_overrun_or_framing = 1'b0; // RQ12
      next_st.full_armed = 1'b0;
      next_st.rx_overrun_or_framing_armed = 1'b0;
    end
    if (accept && avs_write_in) begin
      if (idx == IDX_RATE) begin
        next_st.ebe = avs_writedata_in[RT_EBE];
        next_st.fmt = avs_writedata_in[RT_FMT_HI:RT_FMT_LO];
        next_st.speed = avs_writedata_in[RT_SPD_HI:RT_SPD_LO];
      end else if (idx == IDX_STATUS) begin
        next_st.rx_irq_on = avs_writedata_in[ST_RIE];
        next_st.re = avs_writedata_in[ST_RE];
        next_st.tx_irq_on = avs_writedata_in[ST_TIE];
        next_st.te = avs_writedata_in[ST_TE];
      end else if (idx == IDX_TXDATA) begin
        next_st.tdr = avs_writedata_in[7:0];
        if (st.tx_buffer_empty_armed) next_st.tx_buffer_empty = 1'b0; // RQ5
        next_st.tx_buffer_empty_armed = 1'b0;
      end
    end
    if (next_st.re) next_st.rx_lock = 1'b1; // RQ3

    // 8x bit-rate tick from prescaler or external clock
    div = bit_divisor(st.ebe, st.speed); // RQ21
    div8 = div[PRE_W+2:3];
    next_st.ext_prev = ext_clk;
    next_st.tick8 = 1'b0;
    if (st.fmt == FMT_NRZ_EXT) begin // RQ20
      next_st.pre_cnt = '0;
      next_st.tick8 = ext_clk & ~st.ext_prev;
    end else if (st.pre_cnt >= div8 - 1'b1) begin
      next_st.pre_cnt = '0;
      next_st.tick8 = 1'b1;
    end else begin
      next_st.pre_cnt = st.pre_cnt + 1'b1;
    end
    tick = st.tick8;

    // transmitter
    next_st.te_prev = st.te;
    if (tick) next_st.tx_phase = st.tx_phase + 1'b1;
    bit_tick = tick && st.tx_phase == PHASE_LAST;
    mid_tick = tick && st.tx_phase == PHASE_TX_MID;
    next_st.sclk = st.tx_phase[2];
    next_st.sclk_oe_n = (st.fmt != FMT_NRZ_CLKOUT); // RQ20
    if (!st.te) begin
      next_st.tx_state = TX_OFF;
      next_st.tx_bit = 1'b1;
      next_st.tx_line = 1'b1;
    end else if (!st.te_prev) begin
      next_st.tx_state = TX_PREAMBLE; // RQ1
      next_st.tx_oe_n = 1'b0; // RQ1
      next_st.tx_cnt = 4'h1;
      next_st.tx_phase = 3'h0;
      next_st.tx_bit = 1'b1;
    end else if (bit_tick) begin
      unique case (st.tx_state)
        TX_PREAMBLE: begin
          if (st.tx_cnt == PREAMBLE_BITS) begin
            load_next = 1'b1;
          end else begin
            next_st.tx_cnt = st.tx_cnt + 1'b1;
          end
        end
        TX_FRAME: begin
          if (st.tx_cnt == FRAME_BITS) begin
            load_next = 1'b1;
          end else begin
            next_st.tx_bit = st.tx_shift[0]; // RQ16
            next_st.tx_shift = {1'b1, st.tx_shift[8:1]};
            next_st.tx_cnt = st.tx_cnt + 1'b1;
          end
        end
        TX_IDLE: load_next = 1'b1;
        TX_OFF: load_next = 1'b0;
      endcase
      if (load_next && !next_st.tx_buffer_empty) begin
        next_st.tx_state = TX_FRAME; // RQ6
        next_st.tx_shift = {1'b1, next_st.tdr}; // RQ16
        next_st.tx_bit = 1'b0;
        next_st.tx_cnt = 4'h1;
        next_st.tx_buffer_empty = 1'b1; // RQ15
        next_st.tx_buffer_empty_armed = 1'b0;
      end else if (load_next) begin
        next_st.tx_state = TX_IDLE; // RQ17
        next_st.tx_bit = 1'b1;
      end
    end
    if (st.fmt == FMT_BIPHASE && st.te) begin
      if (bit_tick) next_st.tx_line = ~st.tx_line; // RQ18
      if (mid_tick && st.tx_bit) next_st.tx_line = ~st.tx_line; // RQ18
    end else begin
      next_st.tx_line = next_st.tx_bit;
    end

    // receiver, eight ticks per cell counted from the start edge
    if (!st.re) begin
      next_st.rx_state = RX_IDLE; // RQ3
    end else if (tick) begin
      unique case (st.rx_state)
        RX_IDLE: begin
          if (!rx_line) begin
            next_st.rx_state = RX_CELL; // RQ22
            next_st.rx_phase = 3'h1;
            next_st.rx_cnt = 4'h0;
          end
        end
        RX_CELL: begin
          next_st.rx_phase = st.rx_phase + 1'b1;
          if (st.rx_phase == PHASE_Q1) next_st.q1 = rx_line;
          if (st.rx_phase == PHASE_HALF) next_st.qmid = rx_line; // RQ22
          if (st.rx_phase == PHASE_START_CHK && st.rx_cnt == 4'h0 &&
              st.fmt != FMT_BIPHASE && rx_line) begin
            next_st.rx_state = RX_IDLE;
          end
          if (st.fmt == FMT_BIPHASE) begin
            cell_bit = st.q1 ^ rx_line;
          end else begin
            cell_bit = st.qmid;
          end
          if (st.rx_phase == PHASE_LAST) begin
            next_st.rx_cnt = st.rx_cnt + 1'b1;
            if (st.rx_cnt == 4'h0) begin
              if (cell_bit) next_st.rx_state = RX_IDLE;
            end else if (st.rx_cnt != STOP_CELL) begin
              next_st.rx_shift = {cell_bit, st.rx_shift[7:1]};
            end else if (st.rx_overrun_or_framing && !st.full) begin
              next_st.rx_state = RX_IDLE; // RQ11
            end else if (st.full) begin
              next_st.rx_overrun_or_framing = 1'b1; // RQ7 RQ9
              next_st.rx_state = RX_IDLE; // RQ10
            end else if (cell_bit) begin
              next_st.rdr = st.rx_shift;
              next_st.full = 1'b1; // RQ13
              next_st.rx_state = RX_IDLE;
            end else begin
              next_st.rdr = st.rx_shift; // RQ11
              next_st.rx_overrun_or_framing = 1'b1; // RQ8 RQ9
              next_st.rx_state = RX_BREAK;
            end
          end
        end
        RX_BREAK: begin
          if (rx_line) next_st.rx_state = RX_IDLE;
        end
        default: next_st.rx_state = RX_IDLE;
      endcase
    end

    // shared interrupt request
    next_st.irq = (st.tx_irq_on & st.tx_buffer_empty) | // RQ2
                  (st.rx_irq_on & (st.full | st.rx_overrun_or_framing)); // RQ4
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
      st.bus_wait <= 1'b1;
      st.tx_buffer_empty <= STATUS_RESET[ST_TX_BUFFER_EMPTY]; // RQ19
      st.tx_oe_n <= 1'b1;
      st.sclk_oe_n <= 1'b1;
      st.tx_bit <= 1'b1;
      st.tx_line <= 1'b1;
    end else if (clk_en_in) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata_out = {24'h000000, st.rdata};
  assign avs_waitrequest_out = st.bus_wait;
  assign tx_pin_out = st.tx_line;
  assign tx_pin_oe_n_out = st.tx_oe_n; // RQ1
  assign rx_pin_input_lock_out = st.rx_lock;
  assign serial_clock_pin_out = st.sclk;
  assign serial_clock_pin_oe_n_out = st.sclk_oe_n; // RQ20
  assign shared_irq_line_out = st.irq;

endmodule : async_serial_comm_interface
`default_nettype wire

// ---- tb/sci_asserts.sv ----
// port assertions for the serial interface
`timescale 1ns/10ps
`default_nettype none
module sci_asserts
  import sci_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // pins
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe_n_out,
  input wire logic rx_pin_input_lock_out,
  input wire logic shared_irq_line_out
);
  // ==========================================================================
  // preamble window counter
  logic oe_n_q;
  logic [7:0] pre_cnt;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      oe_n_q <= 1'b1;
      pre_cnt <= 8'h00;
    end else if (clk_en_in) begin
      oe_n_q <= tx_pin_oe_n_out;
      if (oe_n_q && !tx_pin_oe_n_out) pre_cnt <= 8'h01;
      else if (pre_cnt != 8'h00 && pre_cnt < 8'h8C) pre_cnt <= pre_cnt + 8'h01;
      else pre_cnt <= 8'h00;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence stat_wr_done;
    avs_write_in && avs_address_in == 8'h44 && !avs_waitrequest_out;
  endsequence
  sequence rx_on_wr;
    stat_wr_done ##0 avs_writedata_in[3];
  endsequence
  sequence tx_on_wr;
    stat_wr_done ##0 avs_writedata_in[1];
  endsequence
  AST_ANSWER: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out && clk_en_in |=> !avs_waitrequest_out)
    else $error("bus answer late");
  AST_ONE_WAIT: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low too long");
  AST_LOCK_SET: assert property (rx_on_wr |-> ##[1:2] rx_pin_input_lock_out)
    else $error("rx pin not locked");
  AST_LOCK_HOLD: assert property (rx_pin_input_lock_out |=> rx_pin_input_lock_out)
    else $error("rx pin lock lost");
  AST_CONNECT: assert property (tx_on_wr |-> ##[1:2] !tx_pin_oe_n_out)
    else $error("tx pin not connected");
  AST_OE_HOLD: assert property (!tx_pin_oe_n_out |=> !tx_pin_oe_n_out)
    else $error("tx pin released");
  AST_OFF_ONES: assert property (tx_pin_oe_n_out |-> tx_pin_out)
    else $error("tx pin low while off");
  AST_PREAMBLE: assert property (pre_cnt != 8'h00 |-> tx_pin_out)
    else $error("zero inside preamble");
  AST_RESET_STATE: assert property ($fell(reset_in) |-> tx_pin_oe_n_out &&
    !rx_pin_input_lock_out && !shared_irq_line_out && avs_waitrequest_out)
    else $error("bad state after reset");
  AST_STATUS_BITS: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in == 8'h44 |-> avs_readdata_out[31:8] == 24'h000000 &&
    !avs_readdata_out[0]) else $error("status reserved bits set");
endmodule : sci_asserts
bind async_serial_comm_interface sci_asserts chk (
  .clock_in(clock_in),
  .reset_in(reset_in),
  .clk_en_in(clk_en_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .tx_pin_out(tx_pin_out),
  .tx_pin_oe_n_out(tx_pin_oe_n_out),
  .rx_pin_input_lock_out(rx_pin_input_lock_out),
  .shared_irq_line_out(shared_irq_line_out)
);
`default_nettype wire

// ---- tb/remote_station.sv ----
// remote serial station: sends nrz frames and listens to the tx line
`timescale 1ns/10ps
`default_nettype none
module remote_station #(parameter int CELL = 16) (
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // send side
  input wire logic send_in,
  input wire logic [7:0] byte_in,
  input wire logic stop_ok_in,
  output logic line_out,
  output logic busy_out,
  // listen side
  input wire logic line_in,
  output logic [7:0] got_out,
  output logic [7:0] got_count_out
);
  logic [9:0] tx_sr;
  logic [9:0] rx_sr;
  int tcnt;
  int rcnt;
  // ==========================================================================
  // sender, idle line rests high
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      line_out <= 1'b1;
      busy_out <= 1'b0;
      tcnt <= 0;
    end else if (!busy_out && send_in) begin
      tx_sr <= {stop_ok_in, byte_in, 1'b0};
      busy_out <= 1'b1;
      tcnt <= 0;
    end else if (busy_out && tcnt == 10 * CELL) begin
      busy_out <= 1'b0;
      line_out <= 1'b1;
    end else if (busy_out) begin
      line_out <= tx_sr[tcnt / CELL];
      tcnt <= tcnt + 1;
    end
  end
  // ==========================================================================
  // listener, samples mid cell
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rcnt <= 0;
      rx_sr <= 10'h000;
      got_out <= 8'h00;
      got_count_out <= 8'h00;
    end else if (rcnt == 0) begin
      if (!line_in) rcnt <= 1;
    end else if (rcnt == 10 * CELL - 4) begin
      got_out <= rx_sr[8:1];
      got_count_out <= got_count_out + 8'h01;
      rcnt <= 0;
    end else begin
      if (rcnt % CELL == CELL / 2) rx_sr <= {line_in, rx_sr[9:1]};
      rcnt <= rcnt + 1;
    end
  end
endmodule : remote_station
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the serial interface
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sci_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [ADDR_W-1:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, tx_pin_out, tx_pin_oe_n_out;
  logic rx_line, lock, irq, busy, sclk, sclk_oe_n;
  logic send = 1'b0;
  logic clk_en = 1'b1;
  logic stop_ok = 1'b1;
  logic [7:0] sbyte = 8'h00;
  logic [7:0] got, got_n, q, b, b2;
  int errors = 0;
  int total_checks = 0;
  async_serial_comm_interface dut (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .tx_pin_out(tx_pin_out),
    .tx_pin_oe_n_out(tx_pin_oe_n_out),
    .rx_pin_in(rx_line),
    .rx_pin_input_lock_out(lock),
    .serial_clock_pin_in(1'b0),
    .serial_clock_pin_out(sclk),
    .serial_clock_pin_oe_n_out(sclk_oe_n),
    .shared_irq_line_out(irq)
  );
  remote_station #(.CELL(16)) far (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .send_in(send),
    .byte_in(sbyte),
    .stop_ok_in(stop_ok),
    .line_out(rx_line),
    .busy_out(busy),
    .line_in(tx_pin_out),
    .got_out(got),
    .got_count_out(got_n)
  );
  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (n >= 20) begin
      errors++;
      close_out();
    end
    q = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus
  task automatic send_byte(input logic [7:0] v, input logic ok);
    int n;
    n = 0;
    sbyte <= v;
    stop_ok <= ok;
    send <= 1'b1;
    @(posedge clock_in);
    send <= 1'b0;
    do begin
      @(posedge clock_in);
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400) begin
      errors++;
      close_out();
    end
    repeat (40) @(posedge clock_in);
  endtask : send_byte
  task automatic wait_got(input logic [7:0] c);
    int n;
    n = 0;
    while (got_n === c && n < 1000) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 1000) begin
      errors++;
      close_out();
    end
  endtask : wait_got
  // ==========================================================================
  // main sequence
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    b = 8'($urandom(32'h6a39cd5e));
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    bus(1'b0, 8'h44, 8'h00);
    check(q, STATUS_RESET);
    check({4'h0, sclk_oe_n, tx_pin_oe_n_out, lock, irq}, 8'h0C);
    bus(1'b0, 8'h41, 8'h00);
    check(q, 8'h00);
    $display("reset test done");
    bus(1'b1, 8'h40, 8'h04);
    bus(1'b1, 8'h44, 8'h0A);
    check({7'h00, lock}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      b2 = got_n;
      bus(1'b0, 8'h44, 8'h00);
      check(q & 8'h20, 8'h20);
      bus(1'b1, 8'h4C, b);
      bus(1'b0, 8'h44, 8'h00);
      if (i == 0) check(q & 8'h20, 8'h00);
      wait_got(b2);
      check(got, b);
    end
    b2 = 8'hFF;
    repeat (64) begin
      @(posedge clock_in);
      b2[0] = b2[0] & tx_pin_out;
    end
    check(b2, 8'hFF);
    $display("transmit test done");
    b = 8'($urandom);
    send_byte(b, 1'b1);
    bus(1'b0, 8'h44, 8'h00);
    check(q & 8'hC0, 8'h80);
    bus(1'b0, 8'h48, 8'h00);
    check(q, b);
    bus(1'b0, 8'h44, 8'h00);
    check(q & 8'hC0, 8'h00);
    b2 = 8'($urandom);
    send_byte(b, 1'b1);
    send_byte(b2, 1'b1);
    bus(1'b0, 8'h44, 8'h00);
    check(q & 8'hC0, 8'hC0);
    bus(1'b0, 8'h48, 8'h00);
    check(q, b);
    bus(1'b0, 8'h44, 8'h00);
    check(q & 8'hC0, 8'h00);
    send_byte(b2, 1'b0);
    send_byte(b, 1'b1);
    bus(1'b0, 8'h44, 8'h00);
    check(q & 8'hC0, 8'h40);
    bus(1'b0, 8'h48, 8'h00);
    check(q, b2);
    bus(1'b0, 8'h44, 8'h00);
    check(q & 8'hC0, 8'h00);
    $display("receive test done");
    bus(1'b1, 8'h44, 8'h1A);
    send_byte(b, 1'b1);
    check({7'h00, irq}, 8'h01);
    bus(1'b0, 8'h44, 8'h00);
    bus(1'b0, 8'h48, 8'h00);
    repeat (2) @(posedge clock_in);
    check({7'h00, irq}, 8'h00);
    bus(1'b1, 8'h44, 8'h0E);
    repeat (2) @(posedge clock_in);
    check({7'h00, irq}, 8'h01);
    bus(1'b1, 8'h44, 8'h02);
    repeat (2) @(posedge clock_in);
    check({6'h00, irq, lock}, 8'h01);
    $display("interrupt test done");
    // bit clock out at the extra rate set: cell of 64 E cycles, high half
    bus(1'b1, 8'h40, 8'h88);
    repeat (70) @(posedge clock_in);
    b = 8'h00;
    repeat (128) begin
      @(posedge clock_in);
      b = b + {7'h00, sclk};
    end
    check(b, 8'h40);
    check({7'h00, sclk_oe_n}, 8'h00);
    // with the enable low the bit clock must not move
    clk_en <= 1'b0;
    @(posedge clock_in);
    b2 = {7'h00, sclk};
    repeat (40) @(posedge clock_in);
    check({7'h00, sclk}, b2);
    clk_en <= 1'b1;
    $display("clock test done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
